// ### csr_pkg.sv
/*
 * csr_pkg: constants and carrier types for the core special register space.
 * Assumes a 12-bit data address space with 8-bit data, single-cycle accesses.
 */
package csr_pkg;

  // ===========================================================
  // address map
  localparam logic [11:0] CSR_REGION_LO      = 12'hF38;
  localparam logic [11:0] CSR_REGION_HI      = 12'hFFF;
  localparam logic [7:0]  CSR_ACCESS_SPLIT   = 8'h60;
  localparam logic [3:0]  CSR_ACCESS_BANK    = 4'hF;
  localparam logic [11:0] CSR_BANK_PTR_ADDR  = 12'hFE0;
  localparam logic [11:0] CSR_P1_LOW_ADDR    = 12'hFE1;
  localparam logic [11:0] CSR_P1_HIGH_ADDR   = 12'hFE2;
  localparam logic [11:0] CSR_P1_PLUSW_ADDR  = 12'hFE3;
  localparam logic [11:0] CSR_P1_PREINC_ADDR = 12'hFE4;
  localparam logic [11:0] CSR_P1_POSTDEC_ADDR = 12'hFE5;
  localparam logic [11:0] CSR_P1_POSTINC_ADDR = 12'hFE6;
  localparam logic [11:0] CSR_P1_INDIR_ADDR  = 12'hFE7;
  localparam logic [11:0] CSR_WACC_ADDR      = 12'hFE8;
  localparam logic [11:0] CSR_P0_LOW_ADDR    = 12'hFE9;
  localparam logic [11:0] CSR_P0_HIGH_ADDR   = 12'hFEA;
  localparam logic [11:0] CSR_P0_PLUSW_ADDR  = 12'hFEB;
  localparam logic [11:0] CSR_P0_PREINC_ADDR = 12'hFEC;
  localparam logic [11:0] CSR_P0_POSTDEC_ADDR = 12'hFED;
  localparam logic [11:0] CSR_P0_POSTINC_ADDR = 12'hFEE;
  localparam logic [11:0] CSR_P0_INDIR_ADDR  = 12'hFEF;
  localparam logic [11:0] CSR_INTCTL_ADDR    = 12'hFF2;
  localparam logic [11:0] CSR_PRODUCT_LOW_ADDR     = 12'hFF3;
  localparam logic [11:0] CSR_PRODUCT_HIGH_ADDR     = 12'hFF4;
  localparam logic [11:0] CSR_TLAT_ADDR      = 12'hFF5;
  localparam logic [11:0] CSR_TPL_ADDR       = 12'hFF6;
  localparam logic [11:0] CSR_TPH_ADDR       = 12'hFF7;
  localparam logic [11:0] CSR_TPU_ADDR       = 12'hFF8;
  localparam logic [11:0] CSR_PCL_ADDR       = 12'hFF9;
  localparam logic [11:0] CSR_PROGRAM_COUNTER_HIGH_LATCH_ADDR    = 12'hFFA;
  localparam logic [11:0] CSR_PROGRAM_COUNTER_UPPER_LATCH_ADDR    = 12'hFFB;
  localparam logic [11:0] CSR_STKIDX_ADDR    = 12'hFFC;
  localparam logic [11:0] CSR_TOP_OF_STACK_LOW_ADDR      = 12'hFFD;
  localparam logic [11:0] CSR_TOP_OF_STACK_HIGH_ADDR      = 12'hFFE;
  localparam logic [11:0] CSR_TOP_OF_STACK_UPPER_ADDR      = 12'hFFF;

  // ===========================================================
  // field masks and reset values
  localparam logic [7:0] CSR_BANK_PTR_MASK = 8'h0F;
  localparam logic [7:0] CSR_PTR_HIGH_MASK = 8'h0F;
  localparam logic [7:0] CSR_INTCTL_MASK   = 8'hEF;
  localparam logic [7:0] CSR_STKIDX_MASK   = 8'h1F;
  localparam logic [7:0] CSR_U5_MASK       = 8'h1F;
  localparam logic [7:0] CSR_U6_MASK       = 8'h3F;
  localparam logic [7:0] CSR_ZERO_RESET    = 8'h00;
  localparam int         CSR_GIE_BIT       = 7;
  localparam int         CSR_PEIE_BIT      = 6;
  localparam int         CSR_PRIORITY_SCHEME_ENABLE_BIT      = 5;

  // ===========================================================
  // pointer window kinds
  typedef enum logic [2:0] {
    CSR_WIN_NONE    = 3'b000,
    CSR_WIN_INDIR   = 3'b001,
    CSR_WIN_POSTINC = 3'b010,
    CSR_WIN_POSTDEC = 3'b011,
    CSR_WIN_PREINC  = 3'b100,
    CSR_WIN_PLUSW   = 3'b101
  } csr_win_type;

  // core data access request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       access_sel;
    logic       full_addr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } csr_req_type;

  // redirected memory access
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } csr_mem_type;

  // interrupt control fields
  typedef struct packed {
    logic global_high_irq_enable;
    logic peripheral_low_irq_enable;
    logic priority_scheme_enable;
    logic [2:0] ext_irq_edge_select;
  } csr_irq_type;

endpackage : csr_pkg

// ### csr_core_regs.sv
/*
 * csr_core_regs: decode and storage of the core special registers at the top
 * of data memory, with the pointer indirect windows.
 * Assumes the core issues at most one access per cycle, rd and wr exclusive,
 * and that the data memory answers a redirected read in the same cycle.
 */
// Notes on behaviour
// - the special register region spans 0xF38 to 0xFFF, the top of bank 15.
// - unassigned locations in the region are unimplemented and read as zero.
// - special registers are static flops read and written like data memory.
// - indirect windows own no storage and redirect to the pointer's location, plus the signed working value for the plus-w window.
// - the plain window uses the pointer and leaves it unchanged.
// - the post-increment window uses the pointer, then adds one to it.
// - the post-decrement window uses the pointer, then subtracts one from it.
// - the pre-increment window adds one first and uses the new value.
// - interrupt control holds enables in bits 7..5, bit 4 empty, edges low.
// - the bank pointer keeps only bits 3..0; the top four read zero.
// - with access selector zero, offsets 0x60 and up map onto bank 15.
`timescale 1ns/100ps

module csr_core_regs
  import csr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire csr_req_type req,
  input  wire logic [7:0]  mem_rdata,
  output logic [7:0]       rdata,
  output csr_mem_type      mem,
  output csr_irq_type      irq_ctl,
  output logic [3:0]       bank_pointer
);

  // ===========================================================
  // helpers
  function automatic logic [11:0] csr_ptr_next(input logic [11:0] p, input csr_win_type k);
    logic [11:0] n;
    n = p;
    if (k == CSR_WIN_POSTINC || k == CSR_WIN_PREINC) begin
      n = p + 12'h001;
    end else if (k == CSR_WIN_POSTDEC) begin
      n = p - 12'h001;
    end
    return n;
  endfunction : csr_ptr_next

  function automatic logic [11:0] csr_ptr_addr(input logic [11:0] p, input csr_win_type k,
                                               input logic [7:0] w);
    logic [11:0] a;
    a = p;
    if (k == CSR_WIN_PREINC) begin
      a = p + 12'h001;
    end else if (k == CSR_WIN_PLUSW) begin
      a = p + {{4{w[7]}}, w};
    end
    return a;
  endfunction : csr_ptr_addr

  // ===========================================================
  // storage
  logic [7:0]  bank_q;
  logic [11:0] ptr0_q;
  logic [11:0] ptr1_q;
  logic [7:0]  wacc_q;
  logic [7:0]  intctl_q;
  logic [7:0]  product_low_q;
  logic [7:0]  product_high_q;
  logic [7:0]  tlat_q;
  logic [7:0]  tpl_q;
  logic [7:0]  tph_q;
  logic [7:0]  tpu_q;
  logic [7:0]  pcl_q;
  logic [7:0]  program_counter_high_latch_q;
  logic [7:0]  program_counter_upper_latch_q;
  logic [7:0]  stkidx_q;
  logic [7:0]  top_of_stack_low_q;
  logic [7:0]  top_of_stack_high_q;
  logic [7:0]  top_of_stack_upper_q;

  // ===========================================================
  // effective address
  logic [11:0] eff_addr;
  logic        acc;
  always_comb begin
    acc = req.rd | req.wr;
    if (req.full_addr) begin
      eff_addr = req.addr;
    end else if (!req.access_sel && req.addr[7:0] >= CSR_ACCESS_SPLIT) begin
      eff_addr = {CSR_ACCESS_BANK, req.addr[7:0]};
    end else if (!req.access_sel) begin
      eff_addr = {4'h0, req.addr[7:0]};
    end else begin
      eff_addr = {bank_q[3:0], req.addr[7:0]};
    end
  end

  // ===========================================================
  // window decode, one group at a time
  csr_win_type win0;
  csr_win_type win1;
  always_comb begin
    win0 = CSR_WIN_NONE;
    win1 = CSR_WIN_NONE;
    if (eff_addr == CSR_P0_INDIR_ADDR) begin
      win0 = CSR_WIN_INDIR;
    end else if (eff_addr == CSR_P0_POSTINC_ADDR) begin
      win0 = CSR_WIN_POSTINC;
    end else if (eff_addr == CSR_P0_POSTDEC_ADDR) begin
      win0 = CSR_WIN_POSTDEC;
    end else if (eff_addr == CSR_P0_PREINC_ADDR) begin
      win0 = CSR_WIN_PREINC;
    end else if (eff_addr == CSR_P0_PLUSW_ADDR) begin
      win0 = CSR_WIN_PLUSW;
    end else if (eff_addr == CSR_P1_INDIR_ADDR) begin
      win1 = CSR_WIN_INDIR;
    end else if (eff_addr == CSR_P1_POSTINC_ADDR) begin
      win1 = CSR_WIN_POSTINC;
    end else if (eff_addr == CSR_P1_POSTDEC_ADDR) begin
      win1 = CSR_WIN_POSTDEC;
    end else if (eff_addr == CSR_P1_PREINC_ADDR) begin
      win1 = CSR_WIN_PREINC;
    end else if (eff_addr == CSR_P1_PLUSW_ADDR) begin
      win1 = CSR_WIN_PLUSW;
    end
  end

  // redirected address; a window aimed back at a window is not chased further
  logic        redir;
  logic [11:0] redir_addr;
  always_comb begin
    redir      = acc && (win0 != CSR_WIN_NONE || win1 != CSR_WIN_NONE);
    redir_addr = (win0 != CSR_WIN_NONE) ? csr_ptr_addr(ptr0_q, win0, wacc_q)
                                        : csr_ptr_addr(ptr1_q, win1, wacc_q);
  end

  logic wr_reg;
  assign wr_reg = req.wr && !redir;

  // ===========================================================
  // pointers: a direct byte write wins over a window update on the same group
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr0_q <= 12'h000;
    end else if (wr_reg && eff_addr == CSR_P0_LOW_ADDR) begin
      ptr0_q <= {ptr0_q[11:8], req.wdata};
    end else if (wr_reg && eff_addr == CSR_P0_HIGH_ADDR) begin
      ptr0_q <= {req.wdata[3:0], ptr0_q[7:0]};
    end else if (acc && win0 != CSR_WIN_NONE) begin
      ptr0_q <= csr_ptr_next(ptr0_q, win0);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr1_q <= 12'h000;
    end else if (wr_reg && eff_addr == CSR_P1_LOW_ADDR) begin
      ptr1_q <= {ptr1_q[11:8], req.wdata};
    end else if (wr_reg && eff_addr == CSR_P1_HIGH_ADDR) begin
      ptr1_q <= {req.wdata[3:0], ptr1_q[7:0]};
    end else if (acc && win1 != CSR_WIN_NONE) begin
      ptr1_q <= csr_ptr_next(ptr1_q, win1);
    end
  end

  // ===========================================================
  // plain byte registers; undocumented resets are taken as zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_q   <= CSR_ZERO_RESET;
      wacc_q   <= CSR_ZERO_RESET;
      intctl_q <= CSR_ZERO_RESET;
      product_low_q  <= CSR_ZERO_RESET;
      product_high_q  <= CSR_ZERO_RESET;
      tlat_q   <= CSR_ZERO_RESET;
      tpl_q    <= CSR_ZERO_RESET;
      tph_q    <= CSR_ZERO_RESET;
      tpu_q    <= CSR_ZERO_RESET;
      pcl_q    <= CSR_ZERO_RESET;
      program_counter_high_latch_q <= CSR_ZERO_RESET;
      program_counter_upper_latch_q <= CSR_ZERO_RESET;
      stkidx_q <= CSR_ZERO_RESET;
      top_of_stack_low_q   <= CSR_ZERO_RESET;
      top_of_stack_high_q   <= CSR_ZERO_RESET;
      top_of_stack_upper_q   <= CSR_ZERO_RESET;
    end else if (wr_reg) begin
      if (eff_addr == CSR_BANK_PTR_ADDR) begin
        bank_q <= req.wdata & CSR_BANK_PTR_MASK;
      end else if (eff_addr == CSR_WACC_ADDR) begin
        wacc_q <= req.wdata;
      end else if (eff_addr == CSR_INTCTL_ADDR) begin
        intctl_q <= req.wdata & CSR_INTCTL_MASK;
      end else if (eff_addr == CSR_PRODUCT_LOW_ADDR) begin
        product_low_q <= req.wdata;
      end else if (eff_addr == CSR_PRODUCT_HIGH_ADDR) begin
        product_high_q <= req.wdata;
      end else if (eff_addr == CSR_TLAT_ADDR) begin
        tlat_q <= req.wdata;
      end else if (eff_addr == CSR_TPL_ADDR) begin
        tpl_q <= req.wdata;
      end else if (eff_addr == CSR_TPH_ADDR) begin
        tph_q <= req.wdata;
      end else if (eff_addr == CSR_TPU_ADDR) begin
        tpu_q <= req.wdata & CSR_U6_MASK;
      end else if (eff_addr == CSR_PCL_ADDR) begin
        pcl_q <= req.wdata;
      end else if (eff_addr == CSR_PROGRAM_COUNTER_HIGH_LATCH_ADDR) begin
        program_counter_high_latch_q <= req.wdata;
      end else if (eff_addr == CSR_PROGRAM_COUNTER_UPPER_LATCH_ADDR) begin
        program_counter_upper_latch_q <= req.wdata & CSR_U5_MASK;
      end else if (eff_addr == CSR_STKIDX_ADDR) begin
        stkidx_q <= req.wdata & CSR_STKIDX_MASK;
      end else if (eff_addr == CSR_TOP_OF_STACK_LOW_ADDR) begin
        top_of_stack_low_q <= req.wdata;
      end else if (eff_addr == CSR_TOP_OF_STACK_HIGH_ADDR) begin
        top_of_stack_high_q <= req.wdata;
      end else if (eff_addr == CSR_TOP_OF_STACK_UPPER_ADDR) begin
        top_of_stack_upper_q <= req.wdata & CSR_U5_MASK;
      end
    end
  end

  // ===========================================================
  // read mux; anything unmapped in the region, and outside it, reads zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (redir) begin
      rd_mux = mem_rdata;
    end else if (eff_addr >= CSR_REGION_LO) begin
      if (eff_addr == CSR_BANK_PTR_ADDR) begin
        rd_mux = bank_q;
      end else if (eff_addr == CSR_P0_LOW_ADDR) begin
        rd_mux = ptr0_q[7:0];
      end else if (eff_addr == CSR_P0_HIGH_ADDR) begin
        rd_mux = {4'h0, ptr0_q[11:8]};
      end else if (eff_addr == CSR_P1_LOW_ADDR) begin
        rd_mux = ptr1_q[7:0];
      end else if (eff_addr == CSR_P1_HIGH_ADDR) begin
        rd_mux = {4'h0, ptr1_q[11:8]};
      end else if (eff_addr == CSR_WACC_ADDR) begin
        rd_mux = wacc_q;
      end else if (eff_addr == CSR_INTCTL_ADDR) begin
        rd_mux = intctl_q;
      end else if (eff_addr == CSR_PRODUCT_LOW_ADDR) begin
        rd_mux = product_low_q;
      end else if (eff_addr == CSR_PRODUCT_HIGH_ADDR) begin
        rd_mux = product_high_q;
      end else if (eff_addr == CSR_TLAT_ADDR) begin
        rd_mux = tlat_q;
      end else if (eff_addr == CSR_TPL_ADDR) begin
        rd_mux = tpl_q;
      end else if (eff_addr == CSR_TPH_ADDR) begin
        rd_mux = tph_q;
      end else if (eff_addr == CSR_TPU_ADDR) begin
        rd_mux = tpu_q;
      end else if (eff_addr == CSR_PCL_ADDR) begin
        rd_mux = pcl_q;
      end else if (eff_addr == CSR_PROGRAM_COUNTER_HIGH_LATCH_ADDR) begin
        rd_mux = program_counter_high_latch_q;
      end else if (eff_addr == CSR_PROGRAM_COUNTER_UPPER_LATCH_ADDR) begin
        rd_mux = program_counter_upper_latch_q;
      end else if (eff_addr == CSR_STKIDX_ADDR) begin
        rd_mux = stkidx_q;
      end else if (eff_addr == CSR_TOP_OF_STACK_LOW_ADDR) begin
        rd_mux = top_of_stack_low_q;
      end else if (eff_addr == CSR_TOP_OF_STACK_HIGH_ADDR) begin
        rd_mux = top_of_stack_high_q;
      end else if (eff_addr == CSR_TOP_OF_STACK_UPPER_ADDR) begin
        rd_mux = top_of_stack_upper_q;
      end
    end
  end

  // ===========================================================
  // registered outputs: read data and redirect strobes appear one edge later
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
      mem   <= '0;
    end else begin
      rdata     <= req.rd ? rd_mux : 8'h00;
      mem.rd    <= redir & req.rd;
      mem.wr    <= redir & req.wr;
      mem.addr  <= redir ? redir_addr : 12'h000;
      mem.wdata <= redir ? req.wdata : 8'h00;
    end
  end

  // control fields fanned out to the interrupt logic and bank decode
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_ctl      <= '0;
      bank_pointer <= 4'h0;
    end else begin
      irq_ctl.global_high_irq_enable    <= intctl_q[CSR_GIE_BIT];
      irq_ctl.peripheral_low_irq_enable <= intctl_q[CSR_PEIE_BIT];
      irq_ctl.priority_scheme_enable    <= intctl_q[CSR_PRIORITY_SCHEME_ENABLE_BIT];
      irq_ctl.ext_irq_edge_select       <= intctl_q[2:0];
      bank_pointer                      <= bank_q[3:0];
    end
  end

  // ===========================================================
  // checks
  AST_POSTINC_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.rd && eff_addr == CSR_P0_POSTINC_ADDR) |=> (ptr0_q == $past(ptr0_q) + 12'h001 && mem.addr == $past(ptr0_q)))
    else $error("post-increment window misbehaved");
  AST_POSTDEC_STEP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.rd && eff_addr == CSR_P1_POSTDEC_ADDR) |=> (ptr1_q == $past(ptr1_q) - 12'h001 && mem.addr == $past(ptr1_q)))
    else $error("post-decrement window misbehaved");
  AST_PREINC_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.wr && eff_addr == CSR_P0_PREINC_ADDR) |=> (mem.wr && mem.addr == ptr0_q))
    else $error("pre-increment address is not the new pointer");
  AST_INDIR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.rd && eff_addr == CSR_P1_INDIR_ADDR) |=> ($stable(ptr1_q) && mem.rd && mem.addr == ptr1_q))
    else $error("plain window moved its pointer");
  AST_UNMAPPED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.rd && (eff_addr == 12'hFF1 || eff_addr == 12'hF40)) |=> (rdata == 8'h00))
    else $error("unmapped location read nonzero");
  AST_BANK_MASK: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.wr && eff_addr == CSR_BANK_PTR_ADDR) |=>
      (bank_q[3:0] == $past(req.wdata[3:0]) && bank_q[7:4] == 4'h0))
    else $error("bank pointer write or upper bits wrong");
  AST_ACCESS_MAP: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!req.full_addr && !req.access_sel && req.addr[7:0] >= 8'h60) |-> eff_addr[11:8] == 4'hF)
    else $error("access bank did not map to the top bank");
  AST_INTCTL_BIT4: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.wr && eff_addr == CSR_INTCTL_ADDR) |=> ##1
      (irq_ctl.priority_scheme_enable == $past(req.wdata[5], 2) &&
       irq_ctl.global_high_irq_enable == $past(req.wdata[7], 2) && intctl_q[4] == 1'b0))
    else $error("interrupt control field wrong");
  AST_TOP_OF_STACK_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.wr && eff_addr == CSR_TOP_OF_STACK_LOW_ADDR) |=> (top_of_stack_low_q == $past(req.wdata) && $stable(top_of_stack_high_q)))
    else $error("top of stack low byte not independent");
  AST_PLUSW_ADDR: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.rd && eff_addr == CSR_P0_PLUSW_ADDR) |=>
      (mem.addr == $past(ptr0_q + {{4{wacc_q[7]}}, wacc_q}) && $stable(ptr0_q)))
    else $error("plus-w window address or pointer wrong");
  AST_INDIR_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.wr && eff_addr == CSR_P1_INDIR_ADDR) |=>
      (mem.wr && mem.addr == $past(ptr1_q) && mem.wdata == $past(req.wdata)))
    else $error("window write not passed on to memory");

endmodule : csr_core_regs

// ### csr_mem_model.sv
/*
 * csr_mem_model: data memory behind the pointer windows of csr_core_regs.
 * Assumes the bench names, through peek_addr, the location that a window
 * read is expected to select, since the redirected address only shows up
 * on the registered mem port at the same edge that samples the read data.
 */
`timescale 1ns/100ps

module csr_mem_model
  import csr_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire csr_mem_type mem,
  input  wire logic [11:0] peek_addr,
  output logic [7:0]       mem_rdata
);
  // =========================================================
  // storage
  logic [7:0] mem_q [4096];

  // contents distinct within each run of 256 locations, so a wrong address shows up
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem_q[i] = 8'(i) ^ 8'hA5;
    end
  end

  // redirected writes land on the edge that ends the strobe cycle
  always @(posedge ref_clk) begin
    if (mem.wr === 1'b1) begin
      mem_q[mem.addr] <= mem.wdata;
    end
  end

  // combinational answer, valid within the request cycle
  assign mem_rdata = mem_q[peek_addr];
endmodule : csr_mem_model

// ### csr_core_regs_tb.sv
/*
 * csr_core_regs_tb: self-checking bench for csr_core_regs.
 * Assumes one access per request cycle and the registered answer one cycle
 * later; the data memory model answers window reads.
 */
`timescale 1ns/100ps

module csr_core_regs_tb
  import csr_pkg::*;
;
  // =========================================================
  // signals
  logic        ref_clk;
  logic        rst_b;
  csr_req_type req;
  logic [7:0]  mem_rdata;
  logic [7:0]  rdata;
  csr_mem_type mem;
  csr_irq_type irq_ctl;
  logic [3:0]  bank_pointer;
  logic [11:0] peek_addr;
  logic [7:0]  got_rd;
  csr_mem_type got_mem;
  int          err_count;
  int          tests_run;

  // direct registers with their implemented bits
  logic [11:0] m_addr [12] = '{12'hFE8, 12'hFF3, 12'hFF4, 12'hFF2, 12'hFE0, 12'hFEA,
                               12'hFFC, 12'hFFB, 12'hFF8, 12'hFFD, 12'hFFE, 12'hFFF};
  logic [7:0]  m_mask [12] = '{8'hFF, 8'hFF, 8'hFF, 8'hEF, 8'h0F, 8'h0F,
                               8'h1F, 8'h1F, 8'h3F, 8'hFF, 8'hFF, 8'h1F};
  // window walk: address used and pointer value left behind
  logic [11:0] w_addr [10] = '{12'hFEF, 12'hFEE, 12'hFED, 12'hFEC, 12'hFEB,
                               12'hFE6, 12'hFE5, 12'hFE4, 12'hFE7, 12'hFE3};
  logic [11:0] w_ea [10]   = '{12'h123, 12'h123, 12'h124, 12'h124, 12'h122,
                               12'h200, 12'h201, 12'h201, 12'h201, 12'h1FF};
  logic [11:0] w_ptr [10]  = '{12'h123, 12'h124, 12'h123, 12'h124, 12'h124,
                               12'h201, 12'h200, 12'h201, 12'h201, 12'h201};

  csr_core_regs u_csr_core_regs (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .req          (req),
    .mem_rdata    (mem_rdata),
    .rdata        (rdata),
    .mem          (mem),
    .irq_ctl      (irq_ctl),
    .bank_pointer (bank_pointer)
  );

  csr_mem_model u_csr_mem_model (
    .ref_clk   (ref_clk),
    .mem       (mem),
    .peek_addr (peek_addr),
    .mem_rdata (mem_rdata)
  );

  // =========================================================
  // clock, 20 MHz
  always #25 ref_clk = ~ref_clk;

  // =========================================================
  // tasks
  task automatic stop_test();
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk_data(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: data %h, wanted %h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_addr(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: address %h, wanted %h", $time, got, exp);
    end
  endtask : chk_addr

  // one request cycle; answer sampled in the following cycle, then released
  task automatic acc(input logic r, input logic w, input logic [11:0] a,
                     input logic [7:0] d, input logic fa, input logic sel);
    @(negedge ref_clk);
    req.rd         = r;
    req.wr         = w;
    req.addr       = a;
    req.wdata      = d;
    req.full_addr  = fa;
    req.access_sel = sel;
    @(negedge ref_clk);
    got_rd  = rdata;
    got_mem = mem;
    req     = '0;
  endtask : acc

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    acc(1'b0, 1'b1, a, d, 1'b1, 1'b1);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    acc(1'b1, 1'b0, a, 8'h00, 1'b1, 1'b1);
    chk_data(got_rd, exp);
  endtask : rd_chk

  // window read: redirected address, returned data and read strobe
  task automatic win(input logic [11:0] a, input logic [11:0] ea);
    peek_addr = ea;
    acc(1'b1, 1'b0, a, 8'h00, 1'b1, 1'b1);
    chk_addr(got_mem.addr, ea);
    chk_data(got_rd, u_csr_mem_model.mem_q[ea]);
    chk_data({7'h00, got_mem.rd}, 8'h01);
  endtask : win

  // =========================================================
  // watchdog, well beyond the few hundred cycles of the sequence
  initial begin
    #(4000 * 50);
    err_count++;
    stop_test();
  end

  // =========================================================
  // main sequence
  initial begin
    ref_clk   = 1'b0;
    rst_b     = 1'b0;
    req       = '0;
    peek_addr = 12'h000;
    err_count = 0;
    tests_run = 0;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    // documented reset values of the table, program counter and stack index registers
    for (int i = 12'hFF5; i <= 12'hFFC; i++) begin
      rd_chk(12'(i), 8'h00);
    end
    // write all ones, read back only implemented bits
    for (int i = 0; i < 12; i++) begin
      wr(m_addr[i], 8'hFF);
      rd_chk(m_addr[i], m_mask[i]);
    end
    chk_data({2'b00, irq_ctl}, 8'h3F);
    chk_data({4'h0, bank_pointer}, 8'h0F);
    // interrupt control through the access bank: bit 4 dropped, fields in order
    acc(1'b0, 1'b1, 12'h0F2, 8'hB2, 1'b0, 1'b0);
    rd_chk(12'hFF2, 8'hA2);
    chk_data({2'b00, irq_ctl}, 8'h2A);
    // unassigned places in the region hold nothing and redirect nothing
    foreach (m_mask[i]) begin
      if (i < 3) begin
        wr(i == 0 ? 12'hFF0 : (i == 1 ? 12'hFF1 : 12'hF38), 8'hFF);
        chk_data({7'h00, got_mem.wr}, 8'h00);
        rd_chk(i == 0 ? 12'hFF0 : (i == 1 ? 12'hFF1 : 12'hF38), 8'h00);
      end
    end
    // access bank: selector zero ignores the bank pointer
    wr(12'hFE0, 8'h03);
    acc(1'b0, 1'b1, 12'h0E8, 8'h77, 1'b0, 1'b0);
    rd_chk(12'hFE8, 8'h77);
    acc(1'b0, 1'b1, 12'h0E8, 8'h11, 1'b0, 1'b1);
    rd_chk(12'hFE8, 8'h77);
    chk_data({4'h0, bank_pointer}, 8'h03);
    // pointer set-up, working value minus two for the offset windows
    wr(12'hFE8, 8'hFE);
    wr(12'hFE9, 8'h23);
    wr(12'hFEA, 8'h01);
    wr(12'hFE1, 8'h00);
    wr(12'hFE2, 8'h02);
    for (int i = 0; i < 10; i++) begin
      win(w_addr[i], w_ea[i]);
      rd_chk(w_addr[i] >= 12'hFEB ? 12'hFE9 : 12'hFE1, w_ptr[i][7:0]);
      rd_chk(w_addr[i] >= 12'hFEB ? 12'hFEA : 12'hFE2, {4'h0, w_ptr[i][11:8]});
      rd_chk(w_addr[i] >= 12'hFEB ? 12'hFE1 : 12'hFE9, w_addr[i] >= 12'hFEB ? 8'h00 : 8'h24);
    end
    // write through the plain window of pointer 1
    acc(1'b0, 1'b1, 12'hFE7, 8'h5A, 1'b1, 1'b1);
    chk_addr(got_mem.addr, 12'h201);
    chk_data(got_mem.wdata, 8'h5A);
    chk_data({7'h00, got_mem.wr}, 8'h01);
    rd_chk(12'hFE1, 8'h01);
    peek_addr = 12'h201;
    acc(1'b1, 1'b0, 12'hFE7, 8'h00, 1'b1, 1'b1);
    chk_data(got_rd, 8'h5A);
    // pre-increment write lands on the stepped pointer
    acc(1'b0, 1'b1, 12'hFEC, 8'h3C, 1'b1, 1'b1);
    chk_addr(got_mem.addr, 12'h125);
    peek_addr = 12'h125;
    acc(1'b1, 1'b0, 12'hFEF, 8'h00, 1'b1, 1'b1);
    chk_data(got_rd, 8'h3C);
    // second reset in mid-run clears pointers, working value and control copies
    @(negedge ref_clk);
    rst_b = 1'b0;
    repeat (2) @(negedge ref_clk);
    rst_b = 1'b1;
    rd_chk(12'hFE9, 8'h00);
    rd_chk(12'hFE8, 8'h00);
    chk_data({2'b00, irq_ctl}, 8'h00);
    chk_data({4'h0, bank_pointer}, 8'h00);
    stop_test();
  end
endmodule : csr_core_regs_tb
